// >>> design/telemetry_message_framer.sv
/*
 * telemetry message framer: builds native or legacy frames from registers
 * and a byte buffer, parses received frames into a second buffer.
 * assumes: wishbone classic master on clk_i; byte streams from logic on
 * the same clock; receive side always accepts a byte.
 */
// Our own choices: the placing of the registers and register access over Wishbone.
// Operation
// R1 - mode value 2 selects the legacy layout, any other value the native one.
// R2 - in legacy mode software must only place integer words in the buffer.
// R3 - legacy transmit header is id, source, dest, type, high tx, high reply, length, then 3-byte path, words, crc.
// R4 - legacy reply uses the same layout with byte five holding an error code.
// R5 - a native message is header, data field and a closing crc-16.
// R6 - native byte 0 is c8 for initiate or c9 for reply, byte 1 the total count with crc, byte 2 the type.
// R7 - the type byte carries the function code in its top nibble.
// R8 - type bits 3,2 give path length, bits 1,0 the place; source, path of 0-3 bytes and destination follow.
// R9 - every native format starts with the full native header.
// R10 - a telemetry poll carries its word indexes and reply count as data after the header.
// R11 - received frames with bad crc or count are dropped and deliver nothing; the code still writes their bytes into the receive buffer.
`timescale 1ns/100ps
`include "framer_cfg.svh"

module telemetry_message_framer #(
   parameter int BUF_AW = 8
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // transmit byte stream
   output logic      [7:0]  tx_data_o,
   output logic             tx_valid_o,
   input  wire logic        tx_ready_i,
   // receive byte stream
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   // interrupt
   output logic             irq_o
);

   localparam int DEPTH = 1 << BUF_AW;

   // legacy reply needs 76 bytes, count byte limits to 255
   if (BUF_AW < 7 || BUF_AW > 8) begin : g_bad_aw
      $error("BUF_AW must be 7 or 8");
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   // registers
   logic [31:0]             ctrl_q, hdr_q, fwd_q, leg_q;
   logic [7:0]              txlen_q;
   logic [`FR_IRQ_W-1:0]    irq_st_q, irq_en_q, irq_set, irq_clr;
   logic                    ack_q, irq_q;
   logic [31:0]             dat_q;
   logic [7:0]              txbuf [DEPTH];
   logic [7:0]              rxbuf [DEPTH];

   // bus decode
   logic req, wr_en, go;
   assign req   = wb_cyc_i & wb_stb_i;
   assign wr_en = req & wb_we_i & ack_q;
   assign go    = wr_en & (wb_adr_i == `FR_TXGO_OFS) & wb_sel_i[0] & wb_dat_i[0];

   // frame fields
   logic       legacy;
   logic [1:0] fwd_len;
   logic [7:0] hdr_len, tot_len, type_byte;
   logic [8:0] tot_wide;
   assign legacy    = (ctrl_q[7:0] == `FR_MODE_LEGACY);                // [R1]
   assign fwd_len   = (hdr_q[21:20] == 2'h3) ? 2'h3 : hdr_q[21:20];
   assign type_byte = {hdr_q[19:16], fwd_len, hdr_q[23:22]};             // [R7] [R8]
   assign hdr_len   = legacy ? `FR_LEG_HDR_LEN : (`FR_NAT_HDR_BASE + {6'h00, fwd_len});
   assign tot_wide  = {1'b0, hdr_len} + {1'b0, txlen_q} + {1'b0, `FR_CRC_LEN};
   assign tot_len   = tot_wide[7:0];

   function automatic logic [7:0] hdr_byte(input logic [7:0] i);
      logic [7:0] r;
      r = 8'h00;
      if (legacy) begin
         unique case (i)                                                 // [R3] [R4]
            8'h00:   r = leg_q[7:0];
            8'h01:   r = hdr_q[7:0];
            8'h02:   r = hdr_q[15:8];
            8'h03:   r = leg_q[15:8];
            8'h04:   r = leg_q[23:16];
            8'h05:   r = leg_q[31:24];
            8'h06:   r = tot_len;
            8'h07:   r = fwd_q[7:0];
            8'h08:   r = fwd_q[15:8];
            default: r = fwd_q[23:16];
         endcase
      end else begin
         if (i == 8'h00) begin                                           // [R6] [R9]
            r = ctrl_q[`FR_CTRL_REPLY_BIT] ? `FR_SYNC_REPLY : `FR_SYNC_INIT;
         end else if (i == 8'h01) begin
            r = tot_len;
         end else if (i == 8'h02) begin
            r = type_byte;
         end else if (i == 8'h03) begin
            r = hdr_q[7:0];
         end else if (i < `FR_NAT_FWD_POS + {6'h00, fwd_len}) begin     // [R8]
            r = fwd_q[8*(i - `FR_NAT_FWD_POS) +: 8];
         end else begin
            r = hdr_q[15:8];
         end
      end
      return r;
   endfunction

   // transmit engine
   framer_pkg::tx_state_t tx_st_q;
   logic [7:0]  tx_idx_q, tx_nidx, tx_nbyte, tx_data_q;
   logic        tx_valid_q, tx_take, tx_feed, tx_start, tx_bad;
   logic [15:0] tx_crc, tx_crc_nx;
   logic [7:0]  tx_sel_byte;

   assign tx_take  = tx_valid_q & tx_ready_i;
   assign tx_bad   = tot_wide[8] | (tot_wide > 9'(DEPTH) + 9'(`FR_CRC_LEN) + 9'(hdr_len)) | (txlen_q > 8'(DEPTH - 1));
   assign tx_start = go & (tx_st_q == framer_pkg::TX_IDLE) & ~tx_bad;
   assign tx_feed  = tx_take & (tx_idx_q < tot_len - `FR_CRC_LEN);       // [R5]
   assign tx_nidx  = tx_start ? 8'h00 : tx_idx_q + 8'h01;

   always_comb begin
      tx_sel_byte = txbuf[BUF_AW'(tx_nidx - hdr_len)];
      if (tx_nidx < hdr_len) begin
         tx_nbyte = hdr_byte(tx_nidx);
      end else if (tx_nidx == tot_len - `FR_CRC_LEN) begin              // [R5]
         tx_nbyte = tx_crc_nx[15:8];
      end else if (tx_nidx == tot_len - 8'h01) begin
         tx_nbyte = tx_crc[7:0];
      end else begin
         tx_nbyte = tx_sel_byte;                                         // [R10]
      end
   end

   crc16_unit tx_crc_u (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clr_i    (tx_start),
      .en_i     (tx_feed),
      .data_i   (tx_data_q),
      .crc_o    (tx_crc),
      .crc_nx_o (tx_crc_nx)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_st_q    <= framer_pkg::TX_IDLE;
         tx_idx_q   <= 8'h00;
         tx_data_q  <= 8'h00;
         tx_valid_q <= 1'b0;
      end else if (tx_start) begin
         tx_st_q    <= framer_pkg::TX_RUN;
         tx_idx_q   <= 8'h00;
         tx_data_q  <= tx_nbyte;
         tx_valid_q <= 1'b1;
      end else if (tx_take) begin
         tx_idx_q  <= tx_nidx;
         tx_data_q <= tx_nbyte;
         if (tx_idx_q == tot_len - 8'h01) begin
            tx_st_q    <= framer_pkg::TX_IDLE;
            tx_valid_q <= 1'b0;
         end
      end
   end

   // receive engine
   framer_pkg::rx_state_t rx_st_q;
   logic [7:0]  rx_idx_q, rx_tot_q, rx_len_q, rx_hi_q, rx_type_q, len_pos, min_len;
   logic        rx_begin, rx_in, rx_feed, rx_ok, rx_err;
   logic [15:0] rx_crc;

   assign len_pos  = legacy ? `FR_LEG_LEN_POS : `FR_NAT_LEN_POS;
   assign min_len  = legacy ? `FR_LEG_HDR_LEN + `FR_CRC_LEN : `FR_NAT_HDR_BASE + `FR_CRC_LEN;
   // native frames only open on a sync code, stray bytes are dropped
   assign rx_begin = rx_valid_i & (rx_st_q == framer_pkg::RX_IDLE) &
                     (legacy | rx_data_i == `FR_SYNC_INIT | rx_data_i == `FR_SYNC_REPLY);  // [R6]
   assign rx_in    = rx_valid_i & (rx_st_q == framer_pkg::RX_BODY);
   assign rx_feed  = rx_begin | (rx_in & ((rx_idx_q <= len_pos) | (rx_idx_q < rx_tot_q - `FR_CRC_LEN)));
   assign rx_err   = rx_in & (((rx_idx_q == len_pos) & ((rx_data_i < min_len) | ({1'b0, rx_data_i} > 9'(DEPTH))))
                     | ((rx_idx_q > len_pos) & (rx_idx_q == rx_tot_q - 8'h01) & ({rx_hi_q, rx_data_i} != rx_crc)));  // [R11]
   assign rx_ok    = rx_in & (rx_idx_q > len_pos) & (rx_idx_q == rx_tot_q - 8'h01) & ({rx_hi_q, rx_data_i} == rx_crc);

   crc16_unit rx_crc_u (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clr_i    (rx_begin),
      .en_i     (rx_feed),
      .data_i   (rx_data_i),
      .crc_o    (rx_crc),
      .crc_nx_o ()
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_st_q   <= framer_pkg::RX_IDLE;
         rx_idx_q  <= 8'h00;
         rx_tot_q  <= 8'hff;
         rx_hi_q   <= 8'h00;
         rx_type_q <= 8'h00;
         rx_len_q  <= 8'h00;
      end else if (rx_begin) begin
         rx_st_q  <= framer_pkg::RX_BODY;
         rx_idx_q <= 8'h01;
         rx_tot_q <= 8'hff;
         rx_len_q <= 8'h00;                                              // [R11]
      end else if (rx_in) begin
         rx_idx_q <= rx_idx_q + 8'h01;
         if (rx_idx_q == len_pos) rx_tot_q <= rx_data_i;                 // [R6]
         if (rx_idx_q == 8'h02 && !legacy) rx_type_q <= rx_data_i;       // [R7] [R8]
         if (rx_idx_q == 8'h03 && legacy) rx_type_q <= rx_data_i;
         if (rx_idx_q == rx_tot_q - `FR_CRC_LEN) rx_hi_q <= rx_data_i;
         if (rx_ok) rx_len_q <= rx_tot_q;                                // [R11]
         if (rx_ok || rx_err) rx_st_q <= framer_pkg::RX_IDLE;
      end
   end

   // buffer storage; no reset, contents are only meaningful after a fill
   always_ff @(posedge clk_i) begin
      if (rx_begin) rxbuf[0] <= rx_data_i;
      if (rx_in) rxbuf[BUF_AW'(rx_idx_q)] <= rx_data_i;
      if (wr_en && wb_adr_i[11:10] == 2'b01 && wb_sel_i[0]) txbuf[BUF_AW'(wb_adr_i[9:2])] <= wb_dat_i[7:0];
   end

   // control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q   <= `FR_CTRL_RST;
         hdr_q    <= 32'h0000_0000;
         fwd_q    <= 32'h0000_0000;
         leg_q    <= 32'h0000_0000;
         txlen_q  <= 8'h00;
         irq_en_q <= `FR_IRQ_EN_RST;
      end else if (wr_en) begin
         unique case (wb_adr_i)
            `FR_CTRL_OFS:   ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_01ff;
            `FR_HDR_OFS:    hdr_q  <= merge(hdr_q, wb_dat_i, wb_sel_i) & 32'h00ff_ffff;
            `FR_FWD_OFS:    fwd_q  <= merge(fwd_q, wb_dat_i, wb_sel_i) & 32'h00ff_ffff;
            `FR_LEG_OFS:    leg_q  <= merge(leg_q, wb_dat_i, wb_sel_i);
            `FR_TXLEN_OFS:  if (wb_sel_i[0]) txlen_q <= wb_dat_i[7:0];
            `FR_IRQ_EN_OFS: if (wb_sel_i[0]) irq_en_q <= wb_dat_i[`FR_IRQ_W-1:0];
            default:        ;
         endcase
      end
   end

   // interrupt status: a set in the clearing cycle wins
   assign irq_set = {go & tx_bad, rx_err, rx_ok, tx_take & (tx_idx_q == tot_len - 8'h01)};
   assign irq_clr = (wr_en && wb_adr_i == `FR_IRQ_CLR_OFS && wb_sel_i[0]) ? wb_dat_i[`FR_IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_q <= '0;
         irq_q    <= 1'b0;
      end else begin
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
         irq_q    <= |(((irq_st_q & ~irq_clr) | irq_set) & irq_en_q);
      end
   end

   // read mux; data captured in the cycle before ack
   logic [31:0] rd;
   always_comb begin
      rd = 32'h0000_0000;
      if (wb_adr_i[11:10] == 2'b01) begin
         rd = {24'h000000, txbuf[BUF_AW'(wb_adr_i[9:2])]};
      end else if (wb_adr_i[11:10] == 2'b10) begin
         rd = {24'h000000, rxbuf[BUF_AW'(wb_adr_i[9:2])]};
      end else begin
         unique case (wb_adr_i)
            `FR_CTRL_OFS:   rd = ctrl_q;
            `FR_HDR_OFS:    rd = hdr_q;
            `FR_FWD_OFS:    rd = fwd_q;
            `FR_LEG_OFS:    rd = leg_q;
            `FR_TXLEN_OFS:  rd = {24'h000000, txlen_q};
            `FR_STAT_OFS:   rd = {22'h0, rx_st_q == framer_pkg::RX_BODY, tx_st_q == framer_pkg::TX_RUN, tot_len};
            `FR_IRQ_ST_OFS: rd = {28'h0000000, irq_st_q};
            `FR_IRQ_EN_OFS: rd = {28'h0000000, irq_en_q};
            `FR_RXINFO_OFS: rd = {16'h0000, rx_type_q, rx_len_q};
            default:        rd = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req & ~ack_q;
         if (req && !ack_q) dat_q <= rd;
      end
   end

   assign wb_ack_o   = ack_q;
   assign wb_dat_o   = dat_q;
   assign tx_data_o  = tx_data_q;
   assign tx_valid_o = tx_valid_q;
   assign irq_o      = irq_q;

endmodule

// >>> design/framer_cfg.svh
/*
 * register map, field positions, reset values and frame layout constants
 * for the telemetry message framer.
 * assumes: included by bare name from design files; definitions only.
 */
`ifndef FRAMER_CFG_SVH
`define FRAMER_CFG_SVH

// register byte offsets
`define FR_CTRL_OFS      12'h000
`define FR_HDR_OFS       12'h004
`define FR_FWD_OFS       12'h008
`define FR_LEG_OFS       12'h00c
`define FR_TXLEN_OFS     12'h010
`define FR_TXGO_OFS      12'h014
`define FR_STAT_OFS      12'h018
`define FR_IRQ_ST_OFS    12'h01c
`define FR_IRQ_CLR_OFS   12'h020
`define FR_IRQ_EN_OFS    12'h024
`define FR_RXINFO_OFS    12'h028
`define FR_TXBUF_BASE    12'h400
`define FR_RXBUF_BASE    12'h800
`define FR_BUF_WIN_MSB   11

// field positions
`define FR_CTRL_REPLY_BIT 8
`define FR_IRQ_TX_DONE   0
`define FR_IRQ_RX_OK     1
`define FR_IRQ_RX_ERR    2
`define FR_IRQ_TX_ERR    3
`define FR_IRQ_W         4

// reset values
`define FR_CTRL_RST      32'h0000_0000
`define FR_IRQ_EN_RST    4'h0

// frame layout
`define FR_MODE_LEGACY   8'h02
`define FR_SYNC_INIT     8'hc8
`define FR_SYNC_REPLY    8'hc9
`define FR_NAT_HDR_BASE  8'h05
`define FR_LEG_HDR_LEN   8'h0a
`define FR_CRC_LEN       8'h02
`define FR_NAT_LEN_POS   8'h01
`define FR_LEG_LEN_POS   8'h06
`define FR_LEG_FWD_POS   8'h07
`define FR_NAT_FWD_POS   8'h04
`define FR_CRC_INIT      16'h0000
`define FR_CRC_POLY      16'ha001

`endif

// >>> design/framer_pkg.sv
/*
 * types and the crc step shared by the framer and its crc unit.
 * assumes: compiled before the design modules.
 */
package framer_pkg;

   typedef enum logic [0:0] {TX_IDLE, TX_RUN} tx_state_t;
   typedef enum logic [0:0] {RX_IDLE, RX_BODY} rx_state_t;

   // one byte of reflected crc-16, lsb first
   function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                            input logic [7:0]  data,
                                            input logic [15:0] poly);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ poly) : (c >> 1);
      end
      return c;
   endfunction

endpackage

// >>> design/crc16_unit.sv
/*
 * running crc-16 over a byte stream, with restart and look-ahead output.
 * assumes: one clock, synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "framer_cfg.svh"

module crc16_unit (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // byte feed
   input  wire logic        clr_i,
   input  wire logic        en_i,
   input  wire logic [7:0]  data_i,
   // result
   output logic      [15:0] crc_o,
   output logic      [15:0] crc_nx_o
);

   logic [15:0] crc_q;
   logic [15:0] base;

   assign base     = clr_i ? `FR_CRC_INIT : crc_q;
   assign crc_nx_o = framer_pkg::crc_step(base, data_i, `FR_CRC_POLY);
   assign crc_o    = crc_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crc_q <= `FR_CRC_INIT;
      end else if (en_i) begin
         crc_q <= crc_nx_o;
      end else if (clr_i) begin
         crc_q <= `FR_CRC_INIT;
      end
   end

endmodule

// >>> bench/framer_monitor.sv
/* checker on the framer's top ports.
   assumes: bound onto telemetry_message_framer, single clock. */
`timescale 1ns/100ps
`include "framer_cfg.svh"
module framer_monitor (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // streams and interrupt
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_valid_o,
   input wire logic        tx_ready_i,
   input wire logic [7:0]  rx_data_i,
   input wire logic        rx_valid_i,
   input wire logic        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_go;
      s_req ##0 (wb_we_i && wb_adr_i == `FR_TXGO_OFS && wb_dat_i[0] && !tx_valid_o);
   endsequence
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held beyond one cycle");
   property p_ack_resp; s_req |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("no ack one cycle after request");
   property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
   a_dat_hold: assert property (p_dat_hold)
      else $error("read data moved outside ack");
   property p_unmapped; s_req ##0 (!wb_we_i && wb_adr_i == 12'h0fc) |=> wb_dat_o == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_tx_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("tx byte dropped while stalled");
   property p_tx_start; s_go |-> ##2 tx_valid_o; endproperty
   a_tx_start: assert property (p_tx_start)
      else $error("frame did not start after go");
   property p_irq_clear;
      s_req ##0 (wb_we_i && wb_adr_i == `FR_IRQ_CLR_OFS && wb_dat_i[3:0] == 4'hf && !tx_valid_o && !rx_valid_i)
         |-> ##3 !irq_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("irq stayed after clear");
   property p_rst_quiet; disable iff (1'b0) rst_i |=> !wb_ack_o && !tx_valid_o && !irq_o; endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active in reset");
endmodule

// >>> bench/link_partner.sv
/* far-side station: byte sink with stalls, frame source with crc.
   assumes: same clock as the framer; tb calls send(). */
`timescale 1ns/100ps
`include "framer_cfg.svh"
module link_partner (
   input  wire logic       clk_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   input  wire logic       slow_i,
   output logic            tx_ready_o,
   output logic [7:0]      rx_data_o,
   output logic            rx_valid_o
);
   logic [7:0] got[$];
   logic [1:0] ph_q = 2'h0;
   initial begin
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
   end
   // slow mode takes one byte in three
   always @(posedge clk_i) begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
   end
   assign tx_ready_o = !slow_i || (ph_q == 2'h0);
   function automatic logic [15:0] crc(input logic [7:0] b[$]);
      logic [15:0] c;
      c = `FR_CRC_INIT;
      foreach (b[i]) begin
         c ^= {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ `FR_CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   // crc closes the frame, high byte first; bad flips it
   task automatic send(input logic [7:0] b[$], input logic bad);
      logic [15:0] c;
      c = crc(b) ^ {16{bad}};
      b.push_back(c[15:8]);
      b.push_back(c[7:0]);
      foreach (b[i]) begin
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_data_o <= b[i];
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~b[b.size()-1];
   endtask
endmodule

// >>> bench/telemetry_message_framer_tb_top.sv
/* self-checking bench for the telemetry message framer.
   assumes: link_partner and framer_monitor compiled before. */
`timescale 1ns/100ps
`include "framer_cfg.svh"
module telemetry_message_framer_tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic        wb_ack_o;
   logic        tx_valid_o;
   logic        tx_ready_i;
   logic        rx_valid_i;
   logic        irq_o;
   logic        slow = 1'b0;
   logic [7:0]  tx_data_o;
   logic [7:0]  rx_data_i;
   int          miscompares = 0;
   int          samples_checked = 0;
   initial forever #12.5 clk_i = ~clk_i;
   telemetry_message_framer #(.BUF_AW(8)) u_dut (.*);
   link_partner u_link (.clk_i(clk_i), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .slow_i(slow),
      .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(0, 1, "wb timeout");
         summarize;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // go, gather the frame at the sink, then done flag and irq
   task automatic tx_check(input logic [7:0] e[$], input string m);
      int n;
      logic [15:0] c;
      c = u_link.crc(e);
      e.push_back(c[15:8]);
      e.push_back(c[7:0]);
      u_link.got.delete();
      wb(1, `FR_TXGO_OFS, 32'h1);
      n = 0;
      while (u_link.got.size() < e.size() && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      chk(u_link.got.size(), e.size(), m);
      if (u_link.got.size() < e.size()) summarize;
      foreach (e[i]) chk(u_link.got[i], e[i], m);
      wb(0, `FR_IRQ_ST_OFS, 32'h0);
      chk(rd[0], 1'b1, "tx done");
      chk(irq_o, 1'b1, "tx irq");
      wb(1, `FR_IRQ_CLR_OFS, 32'hf);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0, "irq cleared");
   endtask
   task automatic t_regs;
      wb(0, `FR_CTRL_OFS, 32'h0);
      chk(rd, `FR_CTRL_RST, "ctrl reset");
      wb(0, `FR_IRQ_EN_OFS, 32'h0);
      chk(rd[3:0], `FR_IRQ_EN_RST, "irq en reset");
      wb(1, 12'h0fc, 32'hffff_ffff);
      wb(0, 12'h0fc, 32'h0);
      chk(rd, 32'h0, "unmapped");
   endtask
   // five function codes, every path length, both sync codes
   task automatic t_native;
      logic [7:0] e[$];
      logic [3:0] f[5] = '{4'h0, 4'h3, 4'h7, 4'h8, 4'h9};
      logic [7:0] p[3] = '{8'h11, 8'h22, 8'h33};
      wb(1, `FR_IRQ_EN_OFS, 32'h1);
      wb(1, `FR_FWD_OFS, 32'h33_2211);
      for (int i = 0; i < 5; i++) begin
         slow <= i[0];
         wb(1, `FR_CTRL_OFS, {23'h0, i[0], 8'h00});
         wb(1, `FR_HDR_OFS, {8'h00, 2'(i), 2'(i % 4), f[i], 8'h22, 8'h44});
         for (int j = 0; j < i; j++) wb(1, `FR_TXBUF_BASE + 12'(4 * j), 32'(8'ha0 + j));
         wb(1, `FR_TXLEN_OFS, 32'(i));
         e.delete();
         e.push_back(i[0] ? `FR_SYNC_REPLY : `FR_SYNC_INIT);
         e.push_back(8'(7 + i + i % 4));
         e.push_back({f[i], 2'(i % 4), 2'(i)});
         e.push_back(8'h44);
         for (int j = 0; j < i % 4; j++) e.push_back(p[j]);
         e.push_back(8'h22);
         for (int j = 0; j < i; j++) e.push_back(8'(8'ha0 + j));
         tx_check(e, "native tx");
      end
      slow <= 1'b0;
   endtask
   task automatic t_legacy;
      wb(1, `FR_CTRL_OFS, 32'h2);
      wb(1, `FR_LEG_OFS, 32'h250d_6383);
      wb(1, `FR_HDR_OFS, 32'h0000_0403);
      wb(1, `FR_FWD_OFS, 32'h05_0403);
      for (int j = 0; j < 4; j++) wb(1, `FR_TXBUF_BASE + 12'(4 * j), 32'(j)); // integer words only
      wb(1, `FR_TXLEN_OFS, 32'h4);
      tx_check({8'h83, 8'h03, 8'h04, 8'h63, 8'h0d, 8'h25, 8'h10, 8'h03, 8'h04, 8'h05,
                8'h00, 8'h01, 8'h02, 8'h03}, "legacy tx");
   endtask
   // poll frame good, then with a broken crc, then masked
   task automatic t_rx;
      logic [7:0] f[$];
      f = {8'hc8, 8'h0d, 8'h04, 8'h03, 8'h44, 8'h07, 8'h00, 8'h01, 8'h00, 8'h02, 8'h05};
      wb(1, `FR_CTRL_OFS, 32'h0);
      wb(1, `FR_IRQ_EN_OFS, 32'h6);
      u_link.send(f, 1'b0);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b1, "rx irq");
      wb(0, `FR_RXINFO_OFS, 32'h0);
      chk(rd[15:0], 16'h040d, "rx info");
      wb(0, `FR_RXBUF_BASE + 12'h028, 32'h0);
      chk(rd[7:0], 8'h05, "poll count");
      wb(1, `FR_IRQ_CLR_OFS, 32'hf);
      u_link.send(f, 1'b1);
      repeat (2) @(posedge clk_i);
      wb(0, `FR_IRQ_ST_OFS, 32'h0);
      chk(rd[2:1], 2'b10, "bad crc flag");
      wb(0, `FR_RXINFO_OFS, 32'h0);
      chk(rd[7:0], 8'h00, "bad crc length");
      // legacy reply: any byte opens, count sits in byte six
      wb(1, `FR_CTRL_OFS, 32'h2);
      f = {8'h83, 8'h07, 8'h05, 8'he4, 8'h25, 8'h00, 8'h0e, 8'h03, 8'h04, 8'h05, 8'h00, 8'h05};
      u_link.send(f, 1'b0);
      repeat (2) @(posedge clk_i);
      wb(0, `FR_RXINFO_OFS, 32'h0);
      chk(rd[15:0], 16'he40e, "legacy rx info");
      wb(1, `FR_IRQ_EN_OFS, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0, "irq masked");
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_native;
      t_legacy;
      t_rx;
      summarize;
   end
endmodule
bind telemetry_message_framer framer_monitor u_mon (.*);
